// *** include/ptcd_defines.svh ***
// Purpose: Shared constants for the pot transfer command link
// Assumes: 50 MHz system clock on both ends
// Notes: Included by bare name
`ifndef PTCD_DEFINES_SVH
`define PTCD_DEFINES_SVH

// ****************************************
// Address byte
// ****************************************
// Device type nibble, value arbitrary
`define PTCD_DEV_TYPE 4'hA

// ****************************************
// Instruction codes
// ****************************************
`define PTCD_OP_GSAVE 4'h8
`define PTCD_OP_SAVE 4'hE
`define PTCD_OP_LOAD 4'hD
`define PTCD_OP_STEP 4'h2

// ****************************************
// Byte framing
// ****************************************
`define PTCD_ACK_CNT 4'h8
`define PTCD_REL_CNT 4'h9
`define PTCD_ACK_IDX_A 5'h08
`define PTCD_ACK_IDX_I 5'h11
`define PTCD_FIXED_BITS 5'h12

// ****************************************
// Timing
// ****************************************
`define PTCD_QTR_DIV 3'h3
`define PTCD_CLK_MHZ 50
`define PTCD_T_WR_US 5000

`endif

// *** include/ptcd_pkg.sv ***
// Purpose: Types for the pot transfer command link
// Assumes: Nothing
// Notes: Constants live in ptcd_defines.svh
package ptcd_pkg;

  typedef logic [3:0] ptcd_op_t;

  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_ADDR,
    DEV_INSTR,
    DEV_STEP,
    DEV_IGNORE
  } ptcd_dev_state_e;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_START,
    HST_BIT,
    HST_STOP,
    HST_NVWAIT
  } ptcd_hst_state_e;

endpackage : ptcd_pkg

// *** include/ptcd_link_if.sv ***
// Purpose: Two-wire open-drain link between host and device
// Assumes: Pull-ups on both wires
// Notes: Wire levels are resolved here from the enables
`timescale 1ns/1ns
interface ptcd_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // ****************************************
  // Wired-and with pull-up
  // ****************************************
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output host_scl_o, output host_scl_oe_n, output host_sda_o,
                output host_sda_oe_n, input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe_n, input scl, input sda);
endinterface : ptcd_link_if

// *** logic/ptcd_host.sv ***
// Purpose: Bus master issuing transfer and step commands
// Assumes: Device on the far end of ptcd_link_if
// Notes: Link clock is one quarter tick per four system clocks
`timescale 1ns/1ns
`include "ptcd_defines.svh"
module ptcd_host #(
  parameter int NV_WAIT_CYC = `PTCD_T_WR_US * `PTCD_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  ptcd_link_if.host link,
  input wire logic req_i,
  input wire logic [3:0] dev_addr_i,
  input wire ptcd_pkg::ptcd_op_t op_i,
  input wire logic [1:0] pot_i,
  input wire logic [1:0] slot_i,
  input wire logic [3:0] step_cnt_i,
  input wire logic [7:0] step_dir_i,
  output logic busy_o,
  output logic done_o,
  output logic nack_o
);
  import ptcd_pkg::*;

  ptcd_hst_state_e state_reg;
  logic [2:0] div_reg;
  logic [1:0] qtr_reg;
  logic [4:0] idx_reg;
  logic [4:0] last_reg;
  logic [25:0] bits_reg;
  logic save_reg;
  logic nack_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;
  logic done_reg;
  logic busy_reg;
  logic sda_s1;
  logic sda_s2;
  logic [31:0] wait_reg;
  logic tick;
  logic ack_slot;
  logic [3:0] instr_low;

  // ****************************************
  // Pin sync and quarter tick
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      div_reg <= 3'h0;
    else if (state_reg == HST_IDLE || tick)
      div_reg <= 3'h0;
    else
      div_reg <= div_reg + 3'h1;
  end

  assign tick = (div_reg == `PTCD_QTR_DIV);
  assign ack_slot = (idx_reg == `PTCD_ACK_IDX_A) || (idx_reg == `PTCD_ACK_IDX_I);
  // Step keeps low bits zero, global save keeps pot bits zero
  assign instr_low = (op_i == `PTCD_OP_STEP) ? {pot_i, 2'h0} :
                     (op_i == `PTCD_OP_GSAVE) ? {2'h0, slot_i} :
                     {pot_i, slot_i};

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= HST_IDLE;
      qtr_reg <= 2'h0;
      idx_reg <= 5'h00;
      last_reg <= 5'h00;
      bits_reg <= 26'h3FFFFFF;
      save_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      wait_reg <= 32'h0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        HST_IDLE:
        begin
          if (req_i)
          begin
            bits_reg <= {`PTCD_DEV_TYPE, dev_addr_i, 1'b1, op_i, instr_low, 1'b1,
                         (op_i == `PTCD_OP_STEP) ? step_dir_i : 8'h00};
            last_reg <= `PTCD_FIXED_BITS + ((op_i == `PTCD_OP_STEP) ? {1'b0, step_cnt_i} : 5'h00);
            save_reg <= (op_i == `PTCD_OP_GSAVE) || (op_i == `PTCD_OP_SAVE);
            nack_reg <= 1'b0;
            idx_reg <= 5'h00;
            qtr_reg <= 2'h0;
            busy_reg <= 1'b1;
            state_reg <= HST_START;
          end
        end
        HST_START:
        begin
          if (tick)
          begin
            qtr_reg <= qtr_reg + 2'h1;
            if (qtr_reg == 2'h0)
              sda_oe_n_reg <= 1'b0;
            else if (qtr_reg == 2'h1)
            begin
              scl_oe_n_reg <= 1'b0;
              qtr_reg <= 2'h0;
              state_reg <= HST_BIT;
            end
          end
        end
        HST_BIT:
        begin
          if (tick)
          begin
            qtr_reg <= qtr_reg + 2'h1;
            case (qtr_reg)
              2'h0: sda_oe_n_reg <= ack_slot | bits_reg[25];
              2'h1: scl_oe_n_reg <= 1'b1;
              2'h2: nack_reg <= ack_slot & sda_s2;
              default:
              begin
                scl_oe_n_reg <= 1'b0;
                bits_reg <= {bits_reg[24:0], 1'b1};
                idx_reg <= idx_reg + 5'h01;
                if (nack_reg || idx_reg + 5'h01 == last_reg)
                  state_reg <= HST_STOP;
              end
            endcase
          end
        end
        HST_STOP:
        begin
          if (tick)
          begin
            qtr_reg <= qtr_reg + 2'h1;
            case (qtr_reg)
              2'h0: sda_oe_n_reg <= 1'b0;
              2'h1: scl_oe_n_reg <= 1'b1;
              2'h2: sda_oe_n_reg <= 1'b1;
              default:
              begin
                wait_reg <= 32'h0;
                if (save_reg && !nack_reg)
                  state_reg <= HST_NVWAIT;
                else
                begin
                  done_reg <= 1'b1;
                  busy_reg <= 1'b0;
                  state_reg <= HST_IDLE;
                end
              end
            endcase
          end
        end
        HST_NVWAIT:
        begin
          wait_reg <= wait_reg + 32'h1;
          if (wait_reg == NV_WAIT_CYC[31:0])
          begin
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            state_reg <= HST_IDLE;
          end
        end
        default:
        begin
          busy_reg <= 1'b0;
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe_n = scl_oe_n_reg;
  assign link.host_sda_oe_n = sda_oe_n_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign nack_o = nack_reg;

endmodule : ptcd_host

// *** logic/ptcd_device.sv ***
// Purpose: Device end decoding transfer and step commands
// Assumes: Host keeps the link framing; link sampled by clk_i
// Notes: Nonvolatile and wiper effects are reported as pulses
//
// Functional notes
// - Global save code 1000, pots zero, then STOP
// - Single save code 1110, pot, slot, no data
// - Single load code 1101, pot, slot, then STOP
// - Step code 0010, pot, low zeros, bits
// - Nonvolatile write starts only at STOP
// - Step bit high moves up, low down
// - Host waits write time before trusting slot
`timescale 1ns/1ns
`include "ptcd_defines.svh"
module ptcd_device (
  input wire logic clk_i,
  input wire logic nrst_i,
  ptcd_link_if.dev link,
  input wire logic [3:0] strap_addr_i,
  output logic cmd_valid_o,
  output ptcd_pkg::ptcd_op_t cmd_op_o,
  output logic [1:0] cmd_pot_o,
  output logic [1:0] cmd_slot_o,
  output logic step_pulse_o,
  output logic step_up_o,
  output logic nv_write_start_o
);
  import ptcd_pkg::*;

  ptcd_dev_state_e state_reg;
  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;
  logic [3:0] strap_s1;
  logic [3:0] strap_s2;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic ack_reg;
  logic nv_pend_reg;
  logic cmd_valid_reg;
  ptcd_op_t cmd_op_reg;
  logic [1:0] cmd_pot_reg;
  logic [1:0] cmd_slot_reg;
  logic step_pulse_reg;
  logic step_up_reg;
  logic nv_start_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;
  logic instr_ok;
  ptcd_op_t op_in;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end
    else
    begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
    end
    else
    begin
      strap_s1 <= strap_addr_i;
      strap_s2 <= strap_s1;
    end
  end

  // ****************************************
  // Edge and condition detect
  // ****************************************
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_cond = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
  assign stop_cond = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
  assign addr_match = (shift_reg[7:4] == `PTCD_DEV_TYPE) &&
                      (shift_reg[3:0] == strap_s2);
  assign op_in = shift_reg[7:4];
  assign instr_ok = ((op_in == `PTCD_OP_GSAVE) && (shift_reg[3:2] == 2'h0)) ||
                    (op_in == `PTCD_OP_SAVE) ||
                    (op_in == `PTCD_OP_LOAD) ||
                    ((op_in == `PTCD_OP_STEP) && (shift_reg[1:0] == 2'h0));

  // ****************************************
  // Byte receiver and command state
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= DEV_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end
    else if (start_cond)
    begin
      state_reg <= DEV_ADDR;
      cnt_reg <= 4'h0;
    end
    else if (stop_cond)
      state_reg <= DEV_IDLE;
    else
    begin
      if (scl_rise && (state_reg == DEV_ADDR || state_reg == DEV_INSTR))
      begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg < `PTCD_ACK_CNT)
          shift_reg <= {shift_reg[6:0], sda_s2};
      end
      if (scl_fall)
      begin
        case (state_reg)
          DEV_ADDR:
          begin
            if (cnt_reg == `PTCD_ACK_CNT && !addr_match)
              state_reg <= DEV_IGNORE;
            else if (cnt_reg == `PTCD_REL_CNT)
            begin
              cnt_reg <= 4'h0;
              state_reg <= DEV_INSTR;
            end
          end
          DEV_INSTR:
          begin
            if (cnt_reg == `PTCD_ACK_CNT && !instr_ok)
              state_reg <= DEV_IGNORE;
            else if (cnt_reg == `PTCD_REL_CNT)
            begin
              cnt_reg <= 4'h0;
              // Transfers take no data byte and wait for STOP
              state_reg <= (cmd_op_reg == `PTCD_OP_STEP) ? DEV_STEP : DEV_IGNORE;
            end
          end
          DEV_IDLE: state_reg <= DEV_IDLE;
          DEV_STEP: state_reg <= DEV_STEP;
          DEV_IGNORE: state_reg <= DEV_IGNORE;
          default: state_reg <= DEV_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Acknowledge drive
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ack_reg <= 1'b0;
    else if (start_cond || stop_cond)
      ack_reg <= 1'b0;
    else if (scl_fall)
    begin
      if (cnt_reg == `PTCD_ACK_CNT)
        ack_reg <= ((state_reg == DEV_ADDR) && addr_match) ||
                   ((state_reg == DEV_INSTR) && instr_ok);
      else
        ack_reg <= 1'b0;
    end
  end

  // ****************************************
  // Command report
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cmd_valid_reg <= 1'b0;
      cmd_op_reg <= 4'h0;
      cmd_pot_reg <= 2'h0;
      cmd_slot_reg <= 2'h0;
    end
    else
    begin
      cmd_valid_reg <= 1'b0;
      if (scl_fall && !start_cond && !stop_cond && state_reg == DEV_INSTR &&
          cnt_reg == `PTCD_ACK_CNT && instr_ok)
      begin
        cmd_valid_reg <= 1'b1;
        cmd_op_reg <= op_in;
        cmd_pot_reg <= shift_reg[3:2];
        cmd_slot_reg <= shift_reg[1:0];
      end
    end
  end

  // ****************************************
  // Step pulses
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      step_pulse_reg <= 1'b0;
      step_up_reg <= 1'b0;
    end
    else
    begin
      // Pulse follows each fall; a STOP leaves scl high and adds no step
      step_pulse_reg <= scl_fall && state_reg == DEV_STEP;
      if (scl_rise && state_reg == DEV_STEP)
        step_up_reg <= sda_s2;
    end
  end

  // ****************************************
  // Nonvolatile write start
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      nv_pend_reg <= 1'b0;
      nv_start_reg <= 1'b0;
    end
    else
    begin
      nv_start_reg <= 1'b0;
      if (stop_cond)
      begin
        nv_start_reg <= nv_pend_reg;
        nv_pend_reg <= 1'b0;
      end
      else if (start_cond)
        nv_pend_reg <= 1'b0;
      else if (cmd_valid_reg &&
               (cmd_op_reg == `PTCD_OP_GSAVE || cmd_op_reg == `PTCD_OP_SAVE))
        nv_pend_reg <= 1'b1;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = ~ack_reg;
  assign cmd_valid_o = cmd_valid_reg;
  assign cmd_op_o = cmd_op_reg;
  assign cmd_pot_o = cmd_pot_reg;
  assign cmd_slot_o = cmd_slot_reg;
  assign step_pulse_o = step_pulse_reg;
  assign step_up_o = step_up_reg;
  assign nv_write_start_o = nv_start_reg;

endmodule : ptcd_device

// *** tb/ptcd_link_chk.sv ***
// Purpose: Link checks
// Assumes: One clock domain
// Notes: Beside the link
`timescale 1ns/1ns
module ptcd_link_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ****************************************
  // Wire checks
  // ****************************************
  open_drain_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("wire driven high");
  ack_steady_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("ack moves with scl high");
  ack_edge_a: assert property ($fell(dev_sda_oe_n) |-> !scl)
    else $error("ack starts with scl high");
  ack_release_a: assert property ($rose(dev_sda_oe_n) |-> !scl)
    else $error("ack ends with scl high");
  ack_hold_a: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
    else $error("ack too short");
  ack_bound_a: assert property ($fell(dev_sda_oe_n) |-> ##[8:24] dev_sda_oe_n)
    else $error("ack too long");
  scl_high_a: assert property ($rose(scl) |-> scl [*6])
    else $error("scl high too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*6])
    else $error("scl low too short");
  data_setup_a: assert property ($rose(scl) |-> $stable(sda))
    else $error("sda moves at scl rise");
  stop_idle_a: assert property ($rose(sda) && scl |-> (scl && sda) [*4])
    else $error("bus busy after stop");
  start_clock_a: assert property ($fell(sda) && scl |-> ##[1:12] !scl)
    else $error("no clock after start");
endmodule : ptcd_link_chk

// *** tb/pot_transfer_command_decode_test.sv ***
// Purpose: Host and device bench
// Assumes: Shared clock and reset
// Notes: Short nonvolatile wait
`timescale 1ns/1ns
`include "ptcd_defines.svh"
module pot_transfer_command_decode_test;
  import ptcd_pkg::*;
  localparam int NV_CYC = 40;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req = 1'b0;
  logic [3:0] addr_r = 4'h0;
  ptcd_op_t op_r = 4'h0;
  logic [1:0] pot_r = 2'h0;
  logic [1:0] slot_r = 2'h0;
  logic [3:0] cnt_r = 4'h0;
  logic [7:0] dir_r = 8'h00;
  logic [3:0] strap = 4'h5;
  logic busy, done, nack, cmd_valid, step_pulse, step_up, nv_start;
  ptcd_op_t cmd_op;
  logic [1:0] cmd_pot, cmd_slot;
  int num_errors = 0;
  int checks = 0;
  int cmd_seen = 0;
  int nv_seen = 0;
  int step_seen = 0;
  int since_stop = 0;
  logic sda_q = 1'b1;
  logic [7:0] dir_seen = 8'h00;
  always #10 clk_i = ~clk_i;
  // ****************************************
  // Both ends
  // ****************************************
  ptcd_link_if ptcd_link_if_inst ();
  ptcd_host #(.NV_WAIT_CYC(NV_CYC)) ptcd_host_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .link(ptcd_link_if_inst), .req_i(req), .dev_addr_i(addr_r), .op_i(op_r), .pot_i(pot_r),
    .slot_i(slot_r), .step_cnt_i(cnt_r), .step_dir_i(dir_r), .busy_o(busy), .done_o(done),
    .nack_o(nack));
  ptcd_device ptcd_device_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(ptcd_link_if_inst),
    .strap_addr_i(strap), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_pot_o(cmd_pot),
    .cmd_slot_o(cmd_slot), .step_pulse_o(step_pulse), .step_up_o(step_up),
    .nv_write_start_o(nv_start));
  ptcd_link_chk ptcd_link_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .host_scl_o(ptcd_link_if_inst.host_scl_o), .host_scl_oe_n(ptcd_link_if_inst.host_scl_oe_n),
    .host_sda_o(ptcd_link_if_inst.host_sda_o), .host_sda_oe_n(ptcd_link_if_inst.host_sda_oe_n),
    .dev_sda_o(ptcd_link_if_inst.dev_sda_o), .dev_sda_oe_n(ptcd_link_if_inst.dev_sda_oe_n),
    .scl(ptcd_link_if_inst.scl), .sda(ptcd_link_if_inst.sda));
  // ****************************************
  // Checking
  // ****************************************
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  always @(posedge clk_i)
  begin
    sda_q <= ptcd_link_if_inst.sda;
    if (ptcd_link_if_inst.scl && ptcd_link_if_inst.sda && !sda_q)
      since_stop <= 0;
    else
      since_stop <= since_stop + 1;
    if (cmd_valid === 1'b1)
      cmd_seen++;
    if (nv_start === 1'b1)
    begin
      nv_seen++;
      cmp("nv_after_stop", 8'h01, 8'(since_stop <= 8));
    end
    if (step_pulse === 1'b1)
    begin
      step_seen++;
      dir_seen <= {dir_seen[6:0], step_up};
    end
  end
  // ****************************************
  // Command task
  // ****************************************
  task automatic xfer(input string name, input logic [3:0] a, input ptcd_op_t c,
    input logic [1:0] p, input logic [1:0] s, input logic [3:0] n, input logic [7:0] d,
    input logic ok);
    int waited = 0;
    int gap;
    logic hit;
    logic nv;
    logic stp;
    nv = ok && (c == `PTCD_OP_GSAVE || c == `PTCD_OP_SAVE);
    stp = ok && c == `PTCD_OP_STEP;
    @(negedge clk_i);
    cmd_seen = 0;
    nv_seen = 0;
    step_seen = 0;
    dir_seen = 8'h00;
    addr_r = a;
    op_r = c;
    pot_r = p;
    slot_r = s;
    cnt_r = n;
    dir_r = d;
    req = 1'b1;
    @(negedge clk_i);
    req = 1'b0;
    cmp("busy", 8'h01, 8'(busy));
    while (done !== 1'b1 && waited < 3000)
    begin
      @(negedge clk_i);
      waited++;
    end
    hit = done === 1'b1;
    gap = since_stop;
    repeat (8) @(negedge clk_i);
    cmp("done", 8'h01, 8'(hit));
    cmp("idle", 8'h00, 8'(busy));
    cmp("nv_wait", 8'(nv), 8'(gap >= NV_CYC));
    cmp("nack", 8'(!ok), 8'(nack));
    cmp("cmd_count", 8'(ok), 8'(cmd_seen));
    cmp("nv_count", 8'(nv), 8'(nv_seen));
    cmp("step_count", stp ? 8'(n) : 8'h00, 8'(step_seen));
    cmp("step_dirs", (stp && n != 4'h0) ? d >> (4'h8 - n) : 8'h00, dir_seen);
    if (ok)
    begin
      cmp("cmd_op", 8'(c), 8'(cmd_op));
      cmp("cmd_pot", c == `PTCD_OP_GSAVE ? 8'h00 : 8'(p), 8'(cmd_pot));
      cmp("cmd_slot", c == `PTCD_OP_STEP ? 8'h00 : 8'(s), 8'(cmd_slot));
    end
    $display("test %s done", name);
  endtask : xfer
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    xfer("gsave", 4'h5, `PTCD_OP_GSAVE, 2'h2, 2'h3, 4'h0, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++)
      xfer("save", 4'h5, `PTCD_OP_SAVE, 2'(i), 2'(3 - i), 4'h0, 8'h00, 1'b1);
    xfer("load", 4'h5, `PTCD_OP_LOAD, 2'h1, 2'h2, 4'h0, 8'h00, 1'b1);
    xfer("step8", 4'h5, `PTCD_OP_STEP, 2'h3, 2'h1, 4'h8, 8'hA5, 1'b1);
    xfer("step1", 4'h5, `PTCD_OP_STEP, 2'h2, 2'h0, 4'h1, 8'h80, 1'b1);
    xfer("step0", 4'h5, `PTCD_OP_STEP, 2'h0, 2'h0, 4'h0, 8'h00, 1'b1);
    xfer("bad_addr", 4'h6, `PTCD_OP_GSAVE, 2'h0, 2'h1, 4'h0, 8'h00, 1'b0);
    strap = 4'hC;
    xfer("old_addr", 4'h5, `PTCD_OP_SAVE, 2'h1, 2'h1, 4'h0, 8'h00, 1'b0);
    xfer("new_addr", 4'hC, `PTCD_OP_SAVE, 2'h3, 2'h0, 4'h0, 8'h00, 1'b1);
    xfer("bad_op", 4'hC, 4'h9, 2'h1, 2'h0, 4'h0, 8'h00, 1'b0);
    conclude();
  end
  initial
  begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    conclude();
  end
endmodule : pot_transfer_command_decode_test
